/* File: verilog/bmr_consts.vh */
`ifndef BMR_CONSTS_VH
`define BMR_CONSTS_VH
// address map
`define BMR_ROM_BASE 32'h0080_0000
`define BMR_FLASH_BASE 32'h0040_0000
`define BMR_BANK_SIZE 32'h0010_0000
`define BMR_ALIAS_SIZE 32'h0020_0000
// apb register byte offsets
`define BMR_REG_CMD 12'h000
`define BMR_REG_STATUS 12'h004
`define BMR_REG_MAP 12'h008
`define BMR_REG_ERASE 12'h00C
// command register fields
`define BMR_CMD_KEY_POS 24
`define BMR_CMD_KEY 8'h5A
`define BMR_CMD_ARG_POS 8
`define BMR_CMD_SET_BIT 8'h0B
`define BMR_CMD_CLR_BIT 8'h0C
`define BMR_CMD_ERASE_ALL 8'h05
// config bit positions
`define BMR_BIT_SECURITY 0
`define BMR_BIT_BOOT 1
`define BMR_BIT_SWAP 2
`define BMR_NVM_RESET 3'h0
// status bit positions
`define BMR_ST_DONE 0
`define BMR_ST_CMDERR 1
`define BMR_ST_ERASED 2
`define BMR_ST_CLEAR_ARMED 3
`endif

/* File: verilog/bmr_sync.v */
`timescale 1ns/10ps
`default_nettype none
module bmr_sync (
	// clock and control
	input wire ref_clk,
	input wire sys_rst,
	input wire clk_en,
	// signal
	input wire async_in,
	output reg sync_out
);
	reg stage1;
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end
		else if (clk_en)
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // bmr_sync
`default_nettype wire

/* File: verilog/bmr_boot_memory_remap.v */
`timescale 1ns/10ps
`default_nettype none
`include "bmr_consts.vh"
module bmr_boot_memory_remap (
	// clock and control
	input wire ref_clk,
	input wire sys_rst,
	input wire clk_en,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// mass-clear pin, asynchronous
	input wire mass_clear_pin,
	// system bus address decode
	input wire [31:0] sys_addr,
	input wire sys_valid,
	input wire sys_from_debug,
	output reg sel_rom,
	output reg sel_first_bank,
	output reg sel_second_bank,
	output reg [31:0] mem_offset,
	output reg access_denied,
	// current map and config
	output reg [2:0] nonvolatile_config_bits,
	output reg [2:0] active_map,
	output reg security_lock_bit
);
	reg [2:0] nvm;
	reg clear_armed;
	reg erased;
	reg cmd_done;
	reg cmd_err;
	reg map_loaded;
	wire mass_clear_sync;
	wire apb_access;
	wire apb_write;
	wire [7:0] cmd_key;
	wire [7:0] cmd_op;
	wire [7:0] cmd_arg;
	wire arg_ok;
	wire boot_source_bit;
	wire bank_swap_bit;
	reg [2:0] next_nvm;
	reg next_err;

	bmr_sync u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in(mass_clear_pin),
		.sync_out(mass_clear_sync)
	);

	assign pready = 1'b1;
	assign apb_access = psel & penable;
	assign apb_write = apb_access & pwrite & clk_en;
	assign pslverr = apb_access & (paddr != `BMR_REG_CMD) & (paddr != `BMR_REG_STATUS)
		& (paddr != `BMR_REG_MAP) & (paddr != `BMR_REG_ERASE);
	assign cmd_key = pwdata[`BMR_CMD_KEY_POS+7:`BMR_CMD_KEY_POS];
	assign cmd_arg = pwdata[`BMR_CMD_ARG_POS+7:`BMR_CMD_ARG_POS];
	assign cmd_op = pwdata[7:0];
	assign arg_ok = (cmd_arg < 8'h03);
	assign boot_source_bit = active_map[`BMR_BIT_BOOT];
	assign bank_swap_bit = active_map[`BMR_BIT_SWAP];

	// command decode, the config bits are held in the nvm register
	always @*
	begin
		next_nvm = nvm;
		next_err = 1'b0;
		if (apb_write && paddr == `BMR_REG_CMD)
		begin
			if (cmd_key != `BMR_CMD_KEY || !arg_ok)
				next_err = 1'b1;
			else if (cmd_op == `BMR_CMD_SET_BIT)
				next_nvm[cmd_arg[1:0]] = 1'b1;
			else if (cmd_op == `BMR_CMD_CLR_BIT)
			begin
				if (cmd_arg[1:0] == `BMR_BIT_SECURITY)
					next_err = 1'b1;
				else
					next_nvm[cmd_arg[1:0]] = 1'b0;
			end
			else if (cmd_op == `BMR_CMD_ERASE_ALL)
			begin
				if (clear_armed)
					next_nvm[`BMR_BIT_SECURITY] = 1'b0;
			end
			else
				next_err = 1'b1;
		end
		if (mass_clear_sync)
		begin
			next_nvm[`BMR_BIT_BOOT] = 1'b0;
			next_nvm[`BMR_BIT_SWAP] = 1'b0;
		end
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			cmd_done <= 1'b0;
			cmd_err <= 1'b0;
			clear_armed <= 1'b0;
			erased <= 1'b0;
		end
		else if (clk_en)
		begin
			nvm <= next_nvm;
			if (mass_clear_sync)
				clear_armed <= 1'b1;
			if (apb_write && paddr == `BMR_REG_CMD)
			begin
				cmd_done <= 1'b1;
				cmd_err <= next_err;
				if (cmd_key == `BMR_CMD_KEY && cmd_op == `BMR_CMD_ERASE_ALL)
				begin
					erased <= 1'b1;
					// a pin seen in the same cycle keeps the clear armed
					if (!mass_clear_sync)
						clear_armed <= 1'b0;
				end
			end
			else if (apb_write && paddr == `BMR_REG_STATUS)
			begin
				cmd_done <= 1'b0;
				cmd_err <= 1'b0;
				erased <= 1'b0;
			end
		end
	end

	// config bits are non-volatile: not cleared by reset
	initial nvm = `BMR_NVM_RESET;

	// map is captured once after each reset release
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			map_loaded <= 1'b0;
			active_map <= `BMR_NVM_RESET;
			security_lock_bit <= 1'b1;
		end
		else if (clk_en)
		begin
			if (!map_loaded)
			begin
				map_loaded <= 1'b1;
				active_map <= nvm;
			end
			security_lock_bit <= nvm[`BMR_BIT_SECURITY];
		end
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
			nonvolatile_config_bits <= `BMR_NVM_RESET;
		else if (clk_en)
			nonvolatile_config_bits <= nvm;
	end

	// read mux
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && !penable && !pwrite)
		begin
			case (paddr)
				`BMR_REG_STATUS:
					prdata <= {28'h0000000, clear_armed, erased, cmd_err, cmd_done};
				`BMR_REG_MAP:
					prdata <= {24'h000000, 1'b0, map_loaded, nvm[2:1], 1'b0, active_map};
				`BMR_REG_ERASE:
					prdata <= {31'h00000000, mass_clear_sync};
				default:
					prdata <= 32'h0000_0000;
			endcase
		end
	end

	// address decoder
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sel_rom <= 1'b0;
			sel_first_bank <= 1'b0;
			sel_second_bank <= 1'b0;
			mem_offset <= 32'h0000_0000;
			access_denied <= 1'b0;
		end
		else if (clk_en)
		begin
			sel_rom <= 1'b0;
			sel_first_bank <= 1'b0;
			sel_second_bank <= 1'b0;
			mem_offset <= 32'h0000_0000;
			access_denied <= 1'b0;
			if (sys_valid && sys_from_debug && security_lock_bit)
				access_denied <= 1'b1;
			else if (sys_valid && map_loaded)
			begin
				if (sys_addr >= `BMR_ROM_BASE && sys_addr < `BMR_ROM_BASE + `BMR_BANK_SIZE)
				begin
					sel_rom <= 1'b1;
					mem_offset <= sys_addr - `BMR_ROM_BASE;
				end
				else if (sys_addr < `BMR_ALIAS_SIZE && !boot_source_bit)
				begin
					sel_rom <= 1'b1;
					mem_offset <= sys_addr;
				end
				else if (sys_addr < `BMR_ALIAS_SIZE
					|| (sys_addr >= `BMR_FLASH_BASE && sys_addr < `BMR_FLASH_BASE + `BMR_ALIAS_SIZE))
				begin
					// flash alias at zero follows the same bank order
					mem_offset <= sys_addr & (`BMR_BANK_SIZE - 32'h1);
					if (sys_addr[20] ^ bank_swap_bit)
						sel_second_bank <= 1'b1;
					else
						sel_first_bank <= 1'b1;
				end
			end
		end
	end
endmodule // bmr_boot_memory_remap
`default_nettype wire

/* File: testbench/bmr_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module bmr_chk (
	// clock
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// decode and pin
	input wire logic [31:0] sys_addr,
	input wire logic sys_valid,
	input wire logic sys_from_debug,
	input wire logic mass_clear_pin,
	// results
	input wire logic sel_rom,
	input wire logic sel_first_bank,
	input wire logic sel_second_bank,
	input wire logic access_denied,
	input wire logic [2:0] nonvolatile_config_bits,
	input wire logic [2:0] active_map,
	input wire logic security_lock_bit
);
	wire logic go = sys_valid && clk_en && !sys_from_debug;
	wire logic lo = sys_addr < 32'h0020_0000;
	wire logic fl = sys_addr >= 32'h0040_0000 && sys_addr < 32'h0060_0000;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	rom_at_zero_a: assert property (go && lo && !active_map[1] |=> sel_rom)
		else $error("rom not at zero");
	flash_at_zero_a: assert property (go && lo && active_map[1] |=> !sel_rom && (sel_first_bank != sel_second_bank))
		else $error("flash not at zero");
	swap_set_a: assert property (go && fl && active_map[2] |=> sel_second_bank != $past(sys_addr[20]))
		else $error("bank order wrong, swapped");
	swap_clear_a: assert property (go && fl && !active_map[2] |=> sel_second_bank == $past(sys_addr[20]))
		else $error("bank order wrong");
	secure_deny_a: assert property (sys_valid && clk_en && sys_from_debug && security_lock_bit
		|=> access_denied && !sel_rom && !sel_first_bank && !sel_second_bank)
		else $error("debug access not refused");
	map_hold_a: assert property (!$past(sys_rst) |=> $stable(active_map))
		else $error("map changed without reset");
	mass_clear_a: assert property (mass_clear_pin [*6] |-> nonvolatile_config_bits[2:1] == 2'b00)
		else $error("pin did not clear bits");
	lock_track_a: assert property (nonvolatile_config_bits[0] && $past(nonvolatile_config_bits[0]) |-> security_lock_bit)
		else $error("lock not following bit");
	cover property (sel_second_bank);
	cover property (access_denied);
	cover property (mass_clear_pin [*6]);
endmodule // bmr_chk
bind bmr_boot_memory_remap bmr_chk u_chk (.ref_clk, .sys_rst, .clk_en, .sys_addr, .sys_valid,
	.sys_from_debug, .mass_clear_pin, .sel_rom, .sel_first_bank, .sel_second_bank,
	.access_denied, .nonvolatile_config_bits, .active_map, .security_lock_bit);
`default_nettype wire

/* File: testbench/bmr_sys_master.sv */
`timescale 1ns/10ps
`default_nettype none
module bmr_sys_master (
	// clock
	input wire logic ref_clk,
	// decode request
	output var logic [31:0] sys_addr,
	output var logic sys_valid,
	output var logic sys_from_debug
);
	initial
	begin
		sys_addr = 32'h0;
		sys_valid = 1'b0;
		sys_from_debug = 1'b0;
	end
	task automatic fetch(input logic [31:0] a, input logic dbg);
		@(posedge ref_clk);
		sys_addr <= a;
		sys_valid <= 1'b1;
		sys_from_debug <= dbg;
		@(posedge ref_clk);
		sys_valid <= 1'b0;
		// released bus shows no stale address
		sys_addr <= ~a;
	endtask
endmodule // bmr_sys_master
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic ref_clk, sys_rst, clk_en, psel, penable, pwrite, mass_clear_pin, vd;
	logic pready, pslverr, sel_rom, sel_first_bank, sel_second_bank, access_denied, sys_valid;
	logic sys_from_debug;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, sys_addr, rs, ra, mem_offset;
	logic [33:0] ea;
	logic [35:0] ed;
	logic [33:0] aq[$];
	logic [35:0] dq[$];
	int failures, n_tests;
	bmr_boot_memory_remap dut (.ref_clk, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .mass_clear_pin, .sys_addr, .sys_valid,
		.sys_from_debug, .sel_rom, .sel_first_bank, .sel_second_bank, .mem_offset,
		.access_denied, .nonvolatile_config_bits(), .active_map(), .security_lock_bit());
	bmr_sys_master sm (.ref_clk, .sys_addr, .sys_valid, .sys_from_debug);
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x)
		begin
			failures++;
			$display("[FAIL] %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] e);
		aq.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic dec(input logic [31:0] a, input logic dbg, input logic [35:0] e);
		dq.push_back(e);
		sm.fetch(a, dbg);
		@(posedge ref_clk);
	endtask
	task automatic rst();
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic pin();
		mass_clear_pin <= 1'b1;
		repeat (6) @(posedge ref_clk);
		mass_clear_pin <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		if (psel && penable && pready)
		begin
			ea = aq.pop_front();
			chk("pslverr", {31'h0, pslverr}, {31'h0, ea[32]});
			if (ea[33])
				chk("prdata", prdata, ea[31:0]);
		end
		if (vd)
		begin
			ed = dq.pop_front();
			chk("decode", {sel_rom, sel_first_bank, sel_second_bank, access_denied}, ed[35:32]);
			chk("mem_offset", mem_offset, ed[31:0]);
		end
		vd <= sys_valid;
	end
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		failures++;
		tally_and_finish;
	end
	initial
	begin
		rs = 32'h7F5C;
		{sys_rst, clk_en, psel, penable, pwrite, mass_clear_pin, vd} = 7'h60;
		paddr = 12'h0;
		pwdata = 32'h0;
		failures = 0;
		n_tests = 0;
		@(posedge ref_clk);
		rst();
		apb(1'b0, 12'h008, 32'h0, {2'b10, 32'h0000_0040});
		ra = rnd() & 32'h001F_FFFC;
		dec(ra, 1'b0, {4'h8, ra});
		ra = rnd() & 32'h000F_FFFC;
		dec(32'h0040_0000 | ra, 1'b0, {4'h4, ra});
		apb(1'b1, 12'h000, 32'h5A00_010B, 34'h0);
		apb(1'b1, 12'h000, 32'h5A00_020B, 34'h0);
		apb(1'b0, 12'h008, 32'h0, {2'b10, 32'h0000_0070});
		rst();
		apb(1'b0, 12'h008, 32'h0, {2'b10, 32'h0000_0076});
		dec(32'h0000_0000, 1'b0, {4'h2, 32'h0});
		ra = rnd() & 32'h000F_FFFC;
		dec(32'h0050_0000 | ra, 1'b0, {4'h4, ra});
		pin();
		apb(1'b0, 12'h008, 32'h0, {2'b10, 32'h0000_0046});
		apb(1'b1, 12'h000, 32'h5A00_000B, 34'h0);
		apb(1'b1, 12'h000, 32'h5A00_000C, 34'h0);
		dec(rnd() & 32'h001F_FFFC, 1'b1, {4'h1, 32'h0});
		apb(1'b1, 12'h010, rnd(), {2'b01, 32'h0});
		pin();
		apb(1'b1, 12'h000, 32'h5A00_0005, 34'h0);
		dec(32'h0000_0000, 1'b1, {4'h2, 32'h0});
		tally_and_finish;
	end
endmodule // tb_top
`default_nettype wire
